// File: hw/charger_event_regs.vh
`ifndef CHARGER_EVENT_REGS_VH
`define CHARGER_EVENT_REGS_VH

// ----------------------------------------
// state codes
// ----------------------------------------
`define ST_OFF         4'h0
`define ST_WAIT        4'h1
`define ST_SAFE        4'h2
`define ST_PRE         4'h3
`define ST_FULL        4'h4
`define ST_VOLT        4'h5
`define ST_DONE        4'h6
`define ST_DPP         4'h7
`define ST_WEAK_WAIT   4'h8
`define ST_WEAK_SAFE   4'h9
`define ST_WEAK_CHG    4'hA
`define ST_FAULT       4'hB
`define ST_BST_WAIT    4'hC
`define ST_BST_ON      4'hD
`define ST_BST_FAULT   4'hE
`define ST_BST_OL      4'hF
`define ST_CONFIG      4'h0

// ----------------------------------------
// status field positions
// ----------------------------------------
`define STAT_STATE_HI  7
`define STAT_STATE_LO  4
`define STAT_SWITCH    3
`define STAT_THERM     2
`define STAT_SIRQ      1
`define STAT_FIRQ      0

// ----------------------------------------
// interrupt field positions
// ----------------------------------------
`define STATIRQ_STATE  0
`define FAULTA_BATTERY_REMOVED_FLAG  0
`define BSTIRQ_ILIM    0
`define BSTIRQ_OV      1
`define BSTIRQ_BATLO   2

// ----------------------------------------
// reset values
// ----------------------------------------
`define IRQ_RESET      8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS  10
`define PULSE_NS       100
`define PULSE_CYCLES   (`PULSE_NS / `CLK_PERIOD_NS)
`define BST_START_MS   16
`define BST_START_CYC  (`BST_START_MS * 1000000 / `CLK_PERIOD_NS)
`define DEB_CYCLES     16

`endif

// File: hw/charger_event_report.v
`timescale 1ns/100ps
`default_nettype none
`include "charger_event_regs.vh"

module charger_event_report #(
    parameter BST_START_CYCLES = `BST_START_CYC
) (
    input wire sys_clk,
    input wire reset_n,
    input wire input_uv_ok,
    input wire input_ov,
    input wire therm_removed,
    input wire bat_low,
    input wire switch_sense,
    input wire therm_sense,
    input wire boost_enable_pin,
    input wire boost_enable_set,
    input wire boost_enable_clr,
    input wire [3:0] charger_state,
    input wire trans_disable,
    input wire factory_regulation_bit,
    input wire global_mask,
    input wire [7:0] status_irq_mask,
    input wire [7:0] charger_fault_mask_a,
    input wire [7:0] charger_fault_mask_b,
    input wire [7:0] boost_irq_mask,
    input wire [7:0] charger_fault_src_b,
    input wire [7:0] status_src,
    input wire rd_status_irq,
    input wire rd_fault_a,
    input wire rd_fault_b,
    input wire rd_boost_irq,
    output reg [7:0] status_reg_ff,
    output reg [7:0] status_irq_ff,
    output reg [7:0] charger_fault_irq_a,
    output reg [7:0] charger_fault_irq_b,
    output reg [7:0] boost_irq_reg,
    output reg boost_enable_bit,
    output reg event_pin_ff,
    output reg trans_enable_ff,
    output reg converter_on_ff,
    output reg input_switch_ff,
    output reg iin_loop_en_ff,
    output reg ichg_loop_en_ff
);

// ----------------------------------------
// synchronisers and debounce
// ----------------------------------------
localparam NSIG = 8;
wire [NSIG-1:0] raw;
assign raw = {boost_enable_pin, therm_sense, switch_sense, bat_low,
              therm_removed, input_ov, input_uv_ok, 1'b0};
reg [NSIG-1:0] sync1_ff;
reg [NSIG-1:0] sync2_ff;
wire [NSIG-1:0] deb;
genvar g;
generate
    for (g = 0; g < NSIG; g = g + 1) begin : g_deb
        reg [4:0] cnt_ff;
        reg val_ff;
        always @(posedge sys_clk) begin
            if (!reset_n) begin
                cnt_ff <= 5'h00;
                val_ff <= 1'b0;
            end else if (sync2_ff[g] == val_ff) begin
                cnt_ff <= 5'h00;
            end else if (cnt_ff == `DEB_CYCLES - 1) begin
                cnt_ff <= 5'h00;
                val_ff <= sync2_ff[g];
            end else begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
        assign deb[g] = val_ff;
    end
endgenerate

always @(posedge sys_clk) begin
    if (!reset_n) begin
        sync1_ff <= {NSIG{1'b0}};
        sync2_ff <= {NSIG{1'b0}};
    end else begin
        sync1_ff <= raw;
        sync2_ff <= sync1_ff;
    end
end

wire uv_ok = deb[1];
wire ov = deb[2];
wire t_rmv = deb[3];
wire b_low = deb[4];
wire sw_p = deb[5];
wire th_p = deb[6];
wire pin_en = deb[7];

// ----------------------------------------
// helper functions
// ----------------------------------------
function is_boost;
    input [3:0] s;
    begin
        is_boost = (s[3:2] == 2'b11);
    end
endfunction

function is_charging;
    input [3:0] s;
    begin
        case (s)
            `ST_WAIT, `ST_SAFE, `ST_PRE, `ST_FULL, `ST_VOLT, `ST_DPP,
            `ST_WEAK_WAIT, `ST_WEAK_SAFE, `ST_WEAK_CHG:
                is_charging = 1'b1;
            default:
                is_charging = 1'b0;
        endcase
    end
endfunction

function [7:0] rc_update;
    input [7:0] cur;
    input [7:0] set;
    input rd;
    begin
        rc_update = (rd ? 8'h00 : cur) | set;
    end
endfunction

// ----------------------------------------
// boost control
// ----------------------------------------
localparam B_IDLE = 3'b001;
localparam B_START = 3'b010;
localparam B_RUN = 3'b100;
reg [2:0] bst_ff;
reg [2:0] nxt_bst;
reg [23:0] bst_cnt_ff;
reg pin_en_d_ff;
reg bit_d_ff;
reg lockout_ff;
reg [7:0] bst_set;
wire req = pin_en | boost_enable_bit;
wire req_d = pin_en_d_ff | bit_d_ff;
wire toggled = (pin_en & ~pin_en_d_ff) | (boost_enable_bit & ~bit_d_ff);

always @* begin
    nxt_bst = bst_ff;
    bst_set = 8'h00;
    case (bst_ff)
        B_IDLE: begin
            if (req && (!lockout_ff || toggled)) begin
                nxt_bst = B_START;
            end
        end
        B_START: begin
            if (!req) begin
                nxt_bst = B_IDLE;
            end else if (uv_ok) begin
                nxt_bst = B_RUN;
            end else if (bst_cnt_ff >= BST_START_CYCLES - 1) begin
                nxt_bst = B_IDLE;
                bst_set[`BSTIRQ_ILIM] = 1'b1;
            end
        end
        B_RUN: begin
            if (!req) begin
                nxt_bst = B_IDLE;
            end else if (ov) begin
                nxt_bst = B_IDLE;
                bst_set[`BSTIRQ_OV] = 1'b1;
            end else if (!uv_ok) begin
                nxt_bst = B_IDLE;
                bst_set[`BSTIRQ_ILIM] = 1'b1;
            end else if (b_low) begin
                nxt_bst = B_IDLE;
                bst_set[`BSTIRQ_BATLO] = 1'b1;
            end
        end
        default: nxt_bst = B_IDLE;
    endcase
end

always @(posedge sys_clk) begin
    if (!reset_n) begin
        bst_ff <= B_IDLE;
        bst_cnt_ff <= 24'h000000;
        pin_en_d_ff <= 1'b0;
        bit_d_ff <= 1'b0;
        lockout_ff <= 1'b0;
        boost_enable_bit <= 1'b0;
    end else begin
        bst_ff <= nxt_bst;
        pin_en_d_ff <= pin_en;
        bit_d_ff <= boost_enable_bit;
        bst_cnt_ff <= (bst_ff == B_START) ? bst_cnt_ff + 24'h000001
                                          : 24'h000000;
        if (bst_set != 8'h00) begin
            lockout_ff <= 1'b1;
        end else if (bst_ff == B_START) begin
            lockout_ff <= 1'b0;
        end
        if (bst_set[`BSTIRQ_OV] || boost_enable_clr) begin
            boost_enable_bit <= 1'b0;
        end else if (boost_enable_set) begin
            boost_enable_bit <= 1'b1;
        end
    end
end

// ----------------------------------------
// charger state, removal, presence
// ----------------------------------------
reg [3:0] chg_ff;
reg [3:0] nxt_state;
reg [3:0] state_ff;
reg rmv_pend_ff;
reg t_rmv_d_ff;
reg sw_pres_ff;
reg th_pres_ff;
wire boosting = (bst_ff != B_IDLE) || is_boost(state_ff);
wire rmv_edge = t_rmv & ~t_rmv_d_ff;

always @* begin
    if (bst_ff == B_START) begin
        nxt_state = `ST_BST_WAIT;
    end else if (bst_ff == B_RUN) begin
        nxt_state = `ST_BST_ON;
    end else if (lockout_ff && req_d) begin
        nxt_state = `ST_BST_FAULT;
    end else if (rmv_edge) begin
        nxt_state = `ST_FAULT;
    end else if (rmv_pend_ff) begin
        nxt_state = sw_pres_ff ? `ST_WEAK_WAIT : `ST_FAULT;
    end else begin
        nxt_state = chg_ff;
    end
end

always @(posedge sys_clk) begin
    if (!reset_n) begin
        chg_ff <= `ST_OFF;
        state_ff <= `ST_OFF;
        rmv_pend_ff <= 1'b0;
        t_rmv_d_ff <= 1'b0;
        sw_pres_ff <= 1'b0;
        th_pres_ff <= 1'b0;
    end else begin
        chg_ff <= charger_state;
        state_ff <= nxt_state;
        t_rmv_d_ff <= t_rmv;
        if (rmv_edge) begin
            rmv_pend_ff <= 1'b1;
        end else if (!t_rmv) begin
            rmv_pend_ff <= 1'b0;
        end
        if (state_ff == `ST_CONFIG) begin
            sw_pres_ff <= sw_p;
            th_pres_ff <= th_p;
        end
    end
end

wire state_chg = (nxt_state != state_ff);

// ----------------------------------------
// interrupt registers
// ----------------------------------------
reg [7:0] stat_src_d_ff;
reg [7:0] fb_src_d_ff;
wire [7:0] stat_set = (status_src & ~stat_src_d_ff) |
                      {7'h00, state_chg};
wire [7:0] fa_set = {7'h00, rmv_edge};
wire [7:0] fb_set = charger_fault_src_b & ~fb_src_d_ff;
wire [7:0] stat_nxt = rc_update(status_irq_ff, stat_set, rd_status_irq);
wire [7:0] fa_nxt = rc_update(charger_fault_irq_a, fa_set, rd_fault_a);
wire [7:0] fb_nxt = rc_update(charger_fault_irq_b, fb_set, rd_fault_b);
wire [7:0] bi_nxt = rc_update(boost_irq_reg, bst_set, rd_boost_irq);
wire [7:0] fa_keep = boosting ? `IRQ_RESET : fa_nxt;
wire [7:0] fb_keep = boosting ? `IRQ_RESET : fb_nxt;

always @(posedge sys_clk) begin
    if (!reset_n) begin
        status_irq_ff <= `IRQ_RESET;
        charger_fault_irq_a <= `IRQ_RESET;
        charger_fault_irq_b <= `IRQ_RESET;
        boost_irq_reg <= `IRQ_RESET;
        stat_src_d_ff <= 8'h00;
        fb_src_d_ff <= 8'h00;
    end else begin
        stat_src_d_ff <= status_src;
        fb_src_d_ff <= charger_fault_src_b;
        status_irq_ff <= stat_nxt;
        boost_irq_reg <= bi_nxt;
        charger_fault_irq_a <= fa_keep;
        charger_fault_irq_b <= fb_keep;
    end
end

// ----------------------------------------
// event pin pulse
// ----------------------------------------
localparam [7:0] PULSE_LEN = `PULSE_CYCLES;
reg [7:0] pulse_cnt_ff;
reg armed_ff;
reg pulse_lvl_ff;
wire any_unmasked = |(stat_set & ~status_irq_mask) |
                    (!boosting && |(fa_set & ~charger_fault_mask_a)) |
                    (!boosting && |(fb_set & ~charger_fault_mask_b)) |
                    |(bst_set & ~boost_irq_mask);
wire all_clear = (status_irq_ff | charger_fault_irq_a |
                  charger_fault_irq_b | boost_irq_reg) == 8'h00;
wire steady_low = is_charging(nxt_state) && !is_boost(nxt_state);
wire fire = any_unmasked && !global_mask &&
            (armed_ff || all_clear) &&
            (pulse_cnt_ff == 8'h00);

always @(posedge sys_clk) begin
    if (!reset_n) begin
        pulse_cnt_ff <= 8'h00;
        armed_ff <= 1'b1;
        pulse_lvl_ff <= 1'b0;
        event_pin_ff <= 1'b1;
    end else begin
        if (fire) begin
            pulse_cnt_ff <= PULSE_LEN;
            pulse_lvl_ff <= steady_low;
            armed_ff <= 1'b0;
        end else if (pulse_cnt_ff != 8'h00) begin
            pulse_cnt_ff <= pulse_cnt_ff - 8'h01;
        end else if (all_clear) begin
            armed_ff <= 1'b1;
        end
        if (fire) begin
            event_pin_ff <= steady_low;
        end else if (pulse_cnt_ff > 8'h01) begin
            event_pin_ff <= pulse_lvl_ff;
        end else begin
            event_pin_ff <= ~steady_low;
        end
    end
end

// ----------------------------------------
// status and outputs
// ----------------------------------------
wire past_config = (state_ff != `ST_CONFIG);

always @(posedge sys_clk) begin
    if (!reset_n) begin
        status_reg_ff <= 8'h00;
        trans_enable_ff <= 1'b0;
        converter_on_ff <= 1'b0;
        input_switch_ff <= 1'b0;
        iin_loop_en_ff <= 1'b1;
        ichg_loop_en_ff <= 1'b1;
    end else begin
        status_reg_ff[`STAT_STATE_HI:`STAT_STATE_LO] <= nxt_state;
        status_reg_ff[`STAT_SWITCH] <= past_config & sw_pres_ff;
        status_reg_ff[`STAT_THERM] <= past_config & th_pres_ff;
        status_reg_ff[`STAT_SIRQ] <= |stat_nxt;
        status_reg_ff[`STAT_FIRQ] <= |fa_keep | |fb_keep | |bi_nxt;
        trans_enable_ff <= uv_ok & ~ov & ~trans_disable;
        converter_on_ff <= (nxt_bst != B_IDLE) ||
                           (nxt_state != `ST_FAULT &&
                            !is_boost(nxt_state));
        input_switch_ff <= (nxt_bst != B_IDLE) || !boosting;
        iin_loop_en_ff <= ~factory_regulation_bit;
        ichg_loop_en_ff <= ~factory_regulation_bit;
    end
end

endmodule
`default_nettype wire

// File: verification/charger_event_report_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "charger_event_regs.vh"
module charger_event_report_properties (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] charger_state,
    input wire logic trans_disable,
    input wire logic factory_regulation_bit,
    input wire logic global_mask,
    input wire logic [7:0] charger_fault_src_b,
    input wire logic [7:0] status_src,
    input wire logic rd_status_irq,
    input wire logic rd_fault_b,
    input wire logic [7:0] status_reg_ff,
    input wire logic [7:0] status_irq_ff,
    input wire logic [7:0] charger_fault_irq_a,
    input wire logic [7:0] charger_fault_irq_b,
    input wire logic [7:0] boost_irq_reg,
    input wire logic event_pin_ff,
    input wire logic trans_enable_ff,
    input wire logic iin_loop_en_ff,
    input wire logic ichg_loop_en_ff
);
    // ----------------------------------------
    // checks on the event, status, interrupt, transistor and loop-enable outputs
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire logic [3:0] fld;
    wire logic low_st;
    wire logic boost_st;
    assign fld = status_reg_ff[7:4];
    assign boost_st = fld[3:2] == 2'b11;
    assign low_st = !boost_st && fld != `ST_OFF && fld != `ST_DONE &&
                    fld != `ST_FAULT;
    a_stat_summary: assert property (
        status_reg_ff[1] == |status_irq_ff) else $error("stat summary");
    a_fault_summary: assert property (
        status_reg_ff[0] == |{charger_fault_irq_a, charger_fault_irq_b,
        boost_irq_reg}) else $error("fault summary");
    a_state_field: assert property (
        $changed(charger_state) && $past(reset_n) |->
        ##[0:2] status_reg_ff[7:4] == charger_state) else $error("state");
    a_state_event: assert property (
        $changed(charger_state) && $past(reset_n) && !rd_status_irq |->
        ##[1:3] status_irq_ff[0]) else $error("state event");
    a_high_pulse: assert property (
        $rose(event_pin_ff) && low_st && $stable(fld) |->
        event_pin_ff[*8] ##1 event_pin_ff ##1 event_pin_ff
        ##1 (!event_pin_ff || !low_st)) else $error("hi pulse");
    a_low_pulse: assert property (
        $fell(event_pin_ff) && !low_st && $stable(fld) |->
        (!event_pin_ff)[*8] ##1 !event_pin_ff ##1 !event_pin_ff
        ##1 (event_pin_ff || low_st)) else $error("low pulse");
    a_global_mask: assert property (
        global_mask && $past(global_mask) && $past(global_mask, 2) &&
        charger_state == `ST_FAULT |-> !$fell(event_pin_ff))
        else $error("global mask");
    a_read_clears: assert property (
        rd_fault_b && $stable(charger_fault_src_b) |=>
        charger_fault_irq_b == 8'h00) else $error("read clear");
    a_set_wins: assert property (
        rd_status_irq && $rose(status_src[1]) |=> status_irq_ff[1])
        else $error("set lost");
    a_boost_faults: assert property (
        boost_st && $past(boost_st) |-> charger_fault_irq_a == 8'h00 &&
        charger_fault_irq_b == 8'h00) else $error("boost faults");
    a_trans_off: assert property (
        trans_disable && $past(trans_disable) |-> !trans_enable_ff)
        else $error("trans");
    a_factory_loops: assert property (
        factory_regulation_bit && $past(factory_regulation_bit) |->
        !iin_loop_en_ff && !ichg_loop_en_ff) else $error("loops");
endmodule
bind charger_event_report charger_event_report_properties chk (.*);
`default_nettype wire

// File: verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic event_pin_ff,
    output logic rd_status_irq,
    output logic rd_fault_a,
    output logic rd_fault_b,
    output logic rd_boost_irq,
    output int rises
);
    // ----------------------------------------
    // processor side: pin edges and reads
    // ----------------------------------------
    logic pin_q = 1'h1;
    initial {rd_status_irq, rd_fault_a, rd_fault_b, rd_boost_irq} = 4'h0;
    always @(posedge sys_clk) begin
        pin_q <= event_pin_ff;
        if (!reset_n)
            rises <= 0;
        else if (event_pin_ff && !pin_q)
            rises <= rises + 1;
    end
    task automatic read_all();
        @(posedge sys_clk);
        #1;
        {rd_status_irq, rd_fault_a, rd_fault_b, rd_boost_irq} = 4'hF;
        @(posedge sys_clk);
        #1;
        {rd_status_irq, rd_fault_a, rd_fault_b, rd_boost_irq} = 4'h0;
    endtask
endmodule
`default_nettype wire

// File: verification/test_charger_event_report.sv
`timescale 1ns/100ps
`default_nettype none
`include "charger_event_regs.vh"
module test_charger_event_report;
    logic sys_clk = 1'h0, reset_n = 1'h0, input_uv_ok = 1'h0;
    logic input_ov = 1'h0, therm_removed = 1'h0, bat_low = 1'h0;
    logic switch_sense = 1'h1, therm_sense = 1'h1, boost_enable_pin = 1'h0;
    logic boost_enable_set = 1'h0, boost_enable_clr = 1'h0;
    logic trans_disable = 1'h0, factory_regulation_bit = 1'h0;
    logic global_mask = 1'h0;
    logic [3:0] charger_state = `ST_OFF;
    logic [7:0] status_irq_mask = 8'h00, charger_fault_mask_a = 8'h00;
    logic [7:0] charger_fault_mask_b = 8'h00, boost_irq_mask = 8'h00;
    logic [7:0] charger_fault_src_b = 8'h00, status_src = 8'h00;
    wire logic rd_status_irq, rd_fault_a, rd_fault_b, rd_boost_irq;
    wire logic [7:0] status_reg_ff, status_irq_ff, charger_fault_irq_a;
    wire logic [7:0] charger_fault_irq_b, boost_irq_reg;
    wire logic boost_enable_bit, event_pin_ff, trans_enable_ff;
    wire logic converter_on_ff, input_switch_ff;
    wire logic iin_loop_en_ff, ichg_loop_en_ff;
    int rises, n_mismatch = 0, cmp_count = 0;
    charger_event_report #(.BST_START_CYCLES(200)) uut (.*);
    host_model host (.*);
    always #5 sys_clk = ~sys_clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic boost_toggle();
        boost_enable_clr = 1'h1;
        wt(1);
        boost_enable_clr = 1'h0;
        boost_enable_set = 1'h1;
        wt(1);
        boost_enable_set = 1'h0;
    endtask
    function automatic logic [7:0] steady(input logic [3:0] s);
        return (s >= `ST_WAIT && s <= `ST_VOLT || s == `ST_DPP) ?
               8'h00 : 8'h01;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        int r;
        int b;
        void'($urandom(69941));
        wt(2);
        reset_n = 1'h1;
        wt(24);
        charger_state = `ST_WAIT;
        wt(14);
        chk("status", {`ST_WAIT, 4'hE}, status_reg_ff);
        chk("state irq", 8'h01, status_irq_ff);
        chk("pin", steady(charger_state), 8'(event_pin_ff));
        host.read_all();
        r = rises;
        status_src = 8'h02 << ($urandom % 7);
        wt(14);
        chk("rises", 8'h01, 8'(rises - r));
        status_src = 8'hFE;
        wt(14);
        chk("rises", 8'h01, 8'(rises - r));
        chk("stat irq", 8'hFE, status_irq_ff);
        host.read_all();
        status_src = 8'h00;
        chk("stat irq", 8'h00, status_irq_ff);
        $display("charging events done");
        charger_state = `ST_FAULT;
        wt(14);
        chk("pin", steady(charger_state), 8'(event_pin_ff));
        host.read_all();
        r = rises;
        charger_fault_mask_a = 8'($urandom);
        boost_irq_mask = 8'($urandom);
        charger_fault_src_b = 8'h01 << ($urandom % 8);
        wt(14);
        chk("rises", 8'h01, 8'(rises - r));
        chk("fault sum", 8'h01, 8'(status_reg_ff[0]));
        host.read_all();
        charger_fault_src_b = 8'h00;
        for (int i = 0; i < 4; i++) begin
            wt(1);
            b = $urandom % 8;
            r = rises;
            global_mask = (i == 3);
            charger_fault_mask_b = (i == 3) ? 8'h00 : 8'h01 << b;
            charger_fault_src_b = 8'h01 << b;
            wt(14);
            chk("masked", 8'h00, 8'(rises - r));
            chk("fault b", 8'h01 << b, charger_fault_irq_b);
            host.read_all();
            charger_fault_src_b = 8'h00;
        end
        global_mask = 1'h0;
        fork
            host.read_all();
            begin
                wt(1);
                status_src = 8'h02;
            end
        join
        chk("set wins", 8'h02, status_irq_ff);
        status_src = 8'h00;
        $display("halted events done");
        repeat (10) begin
            #40;
            therm_removed = !therm_removed;
        end
        wt(30);
        chk("bounce", 8'h00, charger_fault_irq_a);
        therm_removed = 1'h1;
        wt(30);
        chk("removed", 8'h01, charger_fault_irq_a);
        therm_removed = 1'h0;
        host.read_all();
        input_uv_ok = 1'h1;
        wt(30);
        chk("trans", 8'h01, 8'(trans_enable_ff));
        trans_disable = 1'h1;
        factory_regulation_bit = 1'h1;
        wt(3);
        chk("off", 8'h00, 8'({trans_enable_ff, iin_loop_en_ff,
            ichg_loop_en_ff}));
        trans_disable = 1'h0;
        factory_regulation_bit = 1'h0;
        $display("supply and removal done");
        charger_state = `ST_BST_WAIT;
        input_uv_ok = 1'h0;
        wt(14);
        host.read_all();
        boost_toggle();
        wt(240);
        chk("no vin", 8'h01, boost_irq_reg);
        host.read_all();
        input_uv_ok = 1'h1;
        boost_toggle();
        wt(40);
        input_ov = 1'h1;
        wt(40);
        chk("ov", 8'h02, {boost_irq_reg[7:1], boost_enable_bit});
        host.read_all();
        input_ov = 1'h0;
        wt(30);
        boost_enable_pin = 1'h1;
        wt(40);
        bat_low = 1'h1;
        wt(40);
        chk("bat low", 8'h04, {boost_irq_reg[7:1], converter_on_ff});
        $display("boost done");
        conclude();
    end
endmodule
`default_nettype wire
